/* File: sdpbg_pkg.sv */
// package of constants and types for the sd power and block-gap control block
`default_nettype none
package sdpbg_pkg;

  // ************************************************************
  // register indices and byte addresses
  // ************************************************************
  localparam logic [7:0] IDX_CARD_POWER_CONTROL = 8'h29;
  localparam logic [7:0] IDX_BLOCK_GAP_CONTROL = 8'h2A;
  localparam logic [7:0] IDX_EVENT_STATUS = 8'h30;
  localparam logic [7:0] IDX_EVENT_MASK = 8'h31;
  localparam int ADDR_W = 10;
  localparam logic [9:0] ADDR_CARD_POWER_CONTROL = {IDX_CARD_POWER_CONTROL, 2'h0};
  localparam logic [9:0] ADDR_BLOCK_GAP_CONTROL = {IDX_BLOCK_GAP_CONTROL, 2'h0};
  localparam logic [9:0] ADDR_EVENT_STATUS = {IDX_EVENT_STATUS, 2'h0};
  localparam logic [9:0] ADDR_EVENT_MASK = {IDX_EVENT_MASK, 2'h0};

  // ************************************************************
  // field layouts and reset values
  // ************************************************************
  typedef struct packed {
    logic [3:0] rsvd;
    logic [2:0] volt_sel;
    logic bus_power;
  } sdpbg_power_t;

  typedef struct packed {
    logic [3:0] rsvd;
    logic intr_at_gap;
    logic read_wait_en;
    logic cont;
    logic stop;
  } sdpbg_gap_t;

  localparam logic [2:0] VOLT_3V3 = 3'h7;
  localparam logic [2:0] VOLT_3V0 = 3'h6;
  localparam logic [2:0] VOLT_1V8 = 3'h5;
  localparam sdpbg_power_t POWER_RESET = '{rsvd: 4'h0, volt_sel: VOLT_3V0, bus_power: 1'b0};
  localparam sdpbg_gap_t GAP_RESET = '{rsvd: 4'h0, intr_at_gap: 1'b0, read_wait_en: 1'b0, cont: 1'b0, stop: 1'b0};

  // event status bits
  localparam int EV_W = 3;
  localparam int EV_CARD_INT = 0;
  localparam int EV_POWER_OFF = 1;
  localparam int EV_RESTARTED = 2;
  localparam logic [2:0] EV_RESET = 3'h0;

  // ************************************************************
  // bus encodings and bus-side state
  // ************************************************************
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    SDPBG_IDLE = 2'b00,
    SDPBG_WR = 2'b01,
    SDPBG_RD_WAIT = 2'b11,
    SDPBG_RD_DONE = 2'b10
  } sdpbg_bus_st_t;

  typedef struct packed {
    logic [9:0] addr;
    logic write;
  } sdpbg_req_t;

endpackage
`default_nettype wire

/* File: sdpbg_top.sv */
// sd host power, voltage select and block-gap control with ahb-lite register slave
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - voltage code 7/6/5 valid, resets to 6
// - no card clears bus power automatically
// - interrupt-at-gap bit enables gap interrupt detection
// - gap interrupt only honoured in 4-bit mode
// - read wait enabled pauses reads on data line 2
// - read wait off stops sd clock, no commands
// - suspend/resume offered only with read wait on
// - clear stop, set continue restarts transfer
// - read restart clears continue on data-active rise
// - write restart clears continue on write-active rise
// - upper nibbles reserved: gap reads zero, power resets zero
// - width setting 1 means 4-bit, 0 means 1-bit
module sdpbg_top
(
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic IRQ,
  input wire logic CARD_DETECT,
  input wire logic DATA_WIDTH_4BIT,
  input wire logic DAT_LINE_ACTIVE,
  input wire logic WRITE_XFER_ACTIVE,
  input wire logic XFER_IS_WRITE,
  input wire logic MULTI_BLOCK,
  input wire logic IN_BLOCK_GAP,
  input wire logic HALTED_AT_GAP,
  input wire logic HOLD_READ_DATA,
  input wire logic SD_CLK,
  input wire logic CARD_DAT1_IN,
  output logic CARD_DAT2_OUT,
  output logic CARD_DAT2_OE,
  output logic SD_CLK_STOP,
  output logic CMD_ALLOWED,
  output logic SUSPEND_RESUME_OK,
  output logic BUS_POWER_EN,
  output logic [2:0] BUS_VOLT_SEL,
  output logic STOP_AT_GAP,
  output logic CONTINUE_REQ
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic card_s1_r;
  logic card_s2_r;
  logic clk_s1_r;
  logic clk_s2_r;
  logic clk_s3_r;
  logic dat1_s1_r;
  logic dat1_s2_r;

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      card_s1_r <= 1'b0;
      card_s2_r <= 1'b0;
      clk_s1_r <= 1'b0;
      clk_s2_r <= 1'b0;
      clk_s3_r <= 1'b0;
      dat1_s1_r <= 1'b1;
      dat1_s2_r <= 1'b1;
    end
    else
    begin
      card_s1_r <= CARD_DETECT;
      card_s2_r <= card_s1_r;
      clk_s1_r <= SD_CLK;
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
      dat1_s1_r <= CARD_DAT1_IN;
      dat1_s2_r <= dat1_s1_r;
    end
  end

  logic sdclk_rise;
  logic sdclk_fall;
  assign sdclk_rise = clk_s2_r & ~clk_s3_r;
  assign sdclk_fall = ~clk_s2_r & clk_s3_r;
  // ************************************************************
  // ahb-lite slave
  // ************************************************************
  // reads take one wait state so a read right after a write sees the new value
  sdpbg_pkg::sdpbg_bus_st_t bus_st_r;
  sdpbg_pkg::sdpbg_bus_st_t bus_st_nxt;
  sdpbg_pkg::sdpbg_req_t req_r;
  logic addr_phase;
  logic wr_commit;
  logic rd_capture;

  assign addr_phase = HSEL & HREADY & (HTRANS == sdpbg_pkg::HTRANS_NONSEQ);
  assign wr_commit = (bus_st_r == sdpbg_pkg::SDPBG_WR);
  assign rd_capture = (bus_st_r == sdpbg_pkg::SDPBG_RD_WAIT);
  always_comb
  begin
    bus_st_nxt = sdpbg_pkg::SDPBG_IDLE;
    case (bus_st_r)
      sdpbg_pkg::SDPBG_RD_WAIT: bus_st_nxt = sdpbg_pkg::SDPBG_RD_DONE;
      sdpbg_pkg::SDPBG_IDLE, sdpbg_pkg::SDPBG_WR, sdpbg_pkg::SDPBG_RD_DONE:
      begin
        if (addr_phase)
          bus_st_nxt = HWRITE ? sdpbg_pkg::SDPBG_WR : sdpbg_pkg::SDPBG_RD_WAIT;
      end
      default: bus_st_nxt = sdpbg_pkg::SDPBG_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      bus_st_r <= sdpbg_pkg::SDPBG_IDLE;
      req_r <= '0;
    end
    else
    begin
      bus_st_r <= bus_st_nxt;
      if (addr_phase)
        req_r <= '{addr: HADDR[9:0], write: HWRITE};
    end
  end

  assign HREADYOUT = ~rd_capture;
  assign HRESP = sdpbg_pkg::HRESP_OKAY;
  logic wr_power;
  logic wr_gap;
  logic wr_mask;
  logic rd_status;
  assign wr_power = wr_commit & (req_r.addr == sdpbg_pkg::ADDR_CARD_POWER_CONTROL);
  assign wr_gap = wr_commit & (req_r.addr == sdpbg_pkg::ADDR_BLOCK_GAP_CONTROL);
  assign wr_mask = wr_commit & (req_r.addr == sdpbg_pkg::ADDR_EVENT_MASK);
  assign rd_status = rd_capture & (req_r.addr == sdpbg_pkg::ADDR_EVENT_STATUS);
  // ************************************************************
  // card power control
  // ************************************************************
  sdpbg_pkg::sdpbg_power_t power_r;
  sdpbg_pkg::sdpbg_power_t wr_pwr_val;
  logic volt_code_ok;
  logic power_drop;
  assign wr_pwr_val = sdpbg_pkg::sdpbg_power_t'(HWDATA[7:0]);
  assign volt_code_ok = (wr_pwr_val.volt_sel == sdpbg_pkg::VOLT_3V3) |
                        (wr_pwr_val.volt_sel == sdpbg_pkg::VOLT_3V0) |
                        (wr_pwr_val.volt_sel == sdpbg_pkg::VOLT_1V8);
  // power event fires when an enabled supply is cut by card loss
  assign power_drop = power_r.bus_power & ~card_s2_r;

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
      power_r <= sdpbg_pkg::POWER_RESET;
    else
    begin
      if (wr_power)
      begin
        power_r.rsvd <= wr_pwr_val.rsvd;
        // reserved voltage codes are refused so the rail never sees an undefined level
        if (volt_code_ok)
          power_r.volt_sel <= wr_pwr_val.volt_sel;
      end
      if (!card_s2_r)
        power_r.bus_power <= 1'b0;
      else if (wr_power)
        power_r.bus_power <= wr_pwr_val.bus_power;
    end
  end

  assign BUS_POWER_EN = power_r.bus_power;
  assign BUS_VOLT_SEL = power_r.volt_sel;
  // ************************************************************
  // block gap control
  // ************************************************************
  sdpbg_pkg::sdpbg_gap_t gap_r;
  sdpbg_pkg::sdpbg_gap_t wr_gap_val;
  logic dat_act_d_r;
  logic wr_act_d_r;
  logic restart_seen;
  logic cont_accept;
  assign wr_gap_val = sdpbg_pkg::sdpbg_gap_t'(HWDATA[7:0]);
  assign restart_seen = gap_r.cont &
                        ((~XFER_IS_WRITE & DAT_LINE_ACTIVE & ~dat_act_d_r) |
                         (XFER_IS_WRITE & WRITE_XFER_ACTIVE & ~wr_act_d_r));
  // continue only takes hold on a transfer parked at the gap with stop released
  assign cont_accept = wr_gap & wr_gap_val.cont & ~wr_gap_val.stop & HALTED_AT_GAP;

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      dat_act_d_r <= 1'b0;
      wr_act_d_r <= 1'b0;
    end
    else
    begin
      dat_act_d_r <= DAT_LINE_ACTIVE;
      wr_act_d_r <= WRITE_XFER_ACTIVE;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
      gap_r <= sdpbg_pkg::GAP_RESET;
    else
    begin
      if (wr_gap)
      begin
        gap_r.intr_at_gap <= wr_gap_val.intr_at_gap;
        gap_r.read_wait_en <= wr_gap_val.read_wait_en;
        gap_r.stop <= wr_gap_val.stop;
      end
      gap_r.rsvd <= 4'h0;
      if (cont_accept)
        gap_r.cont <= 1'b1;
      else if (restart_seen)
        gap_r.cont <= 1'b0;
    end
  end

  assign STOP_AT_GAP = gap_r.stop;
  assign CONTINUE_REQ = gap_r.cont & ~gap_r.stop;
  assign SUSPEND_RESUME_OK = gap_r.read_wait_en;
  // ************************************************************
  // read wait and card interrupt on the sd link
  // ************************************************************
  logic dat2_drive_r;
  logic clk_stop_r;
  logic card_int_hit;
  // line 2 changes after a falling sd clock edge so the card samples it stable
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
      dat2_drive_r <= 1'b0;
    else if (sdclk_fall)
      dat2_drive_r <= HOLD_READ_DATA & gap_r.read_wait_en;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
      clk_stop_r <= 1'b0;
    else
      clk_stop_r <= HOLD_READ_DATA & ~gap_r.read_wait_en;
  end

  assign CARD_DAT2_OUT = 1'b0;
  assign CARD_DAT2_OE = dat2_drive_r;
  assign SD_CLK_STOP = clk_stop_r;
  assign CMD_ALLOWED = ~clk_stop_r;
  // card pulls line 1 low in the gap to signal; 1-bit mode ignores the enable
  assign card_int_hit = sdclk_rise & ~dat1_s2_r & gap_r.intr_at_gap &
                        DATA_WIDTH_4BIT & MULTI_BLOCK & IN_BLOCK_GAP;

  // ************************************************************
  // event status, mask and interrupt
  // ************************************************************
  logic [sdpbg_pkg::EV_W-1:0] ev_status_r;
  logic [sdpbg_pkg::EV_W-1:0] ev_mask_r;
  logic [sdpbg_pkg::EV_W-1:0] ev_set;

  assign ev_set[sdpbg_pkg::EV_CARD_INT] = card_int_hit;
  assign ev_set[sdpbg_pkg::EV_POWER_OFF] = power_drop;
  assign ev_set[sdpbg_pkg::EV_RESTARTED] = restart_seen;
  // a new event in the clearing read survives: set wins over clear
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
      ev_status_r <= sdpbg_pkg::EV_RESET;
    else if (rd_status)
      ev_status_r <= ev_set;
    else
      ev_status_r <= ev_status_r | ev_set;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
      ev_mask_r <= sdpbg_pkg::EV_RESET;
    else if (wr_mask)
      ev_mask_r <= HWDATA[sdpbg_pkg::EV_W-1:0];
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
      IRQ <= 1'b0;
    else
      IRQ <= |(ev_status_r & ev_mask_r);
  end

  // ************************************************************
  // read data
  // ************************************************************
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (req_r.addr)
      sdpbg_pkg::ADDR_CARD_POWER_CONTROL: rd_mux = {24'h00_0000, power_r};
      sdpbg_pkg::ADDR_BLOCK_GAP_CONTROL: rd_mux = {24'h00_0000, 4'h0, gap_r[3:0]};
      sdpbg_pkg::ADDR_EVENT_STATUS: rd_mux = {29'h0000_0000, ev_status_r};
      sdpbg_pkg::ADDR_EVENT_MASK: rd_mux = {29'h0000_0000, ev_mask_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
      HRDATA <= 32'h0000_0000;
    else if (rd_capture)
      HRDATA <= rd_mux;
  end

endmodule
`default_nettype wire

/* File: sdpbg_properties.sv */
// port-level checker for the sd power and block-gap block
`timescale 1ns/1ps
`default_nettype none
module sdpbg_properties
(
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic CARD_DETECT,
  input wire logic DAT_LINE_ACTIVE,
  input wire logic WRITE_XFER_ACTIVE,
  input wire logic XFER_IS_WRITE,
  input wire logic HALTED_AT_GAP,
  input wire logic SD_CLK_STOP,
  input wire logic CMD_ALLOWED,
  input wire logic SUSPEND_RESUME_OK,
  input wire logic BUS_POWER_EN,
  input wire logic [2:0] BUS_VOLT_SEL,
  input wire logic STOP_AT_GAP,
  input wire logic CONTINUE_REQ
);
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);
  // ****
  // bus handshake
  // ****
  sequence taken;
    HSEL && HREADY && HTRANS == sdpbg_pkg::HTRANS_NONSEQ;
  endsequence
  sequence one_wait;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  chk_rd_wait: assert property (taken and !HWRITE |=> one_wait)
    else $error("read data phase not one wait");
  chk_wr_nowait: assert property (taken and HWRITE |=> HREADYOUT)
    else $error("write data phase stalled");
  // ****
  // power, clock stop and continue
  // ****
  chk_volt_rst: assert property ($rose(RST_B) |-> BUS_VOLT_SEL == sdpbg_pkg::VOLT_3V0 && !BUS_POWER_EN)
    else $error("power register not at reset value");
  // card detect passes a two-stage synchronizer first
  chk_power_nocard: assert property ((!CARD_DETECT) [*4] |=> !BUS_POWER_EN)
    else $error("bus power kept without card");
  chk_cmd_clk: assert property (CMD_ALLOWED == !SD_CLK_STOP)
    else $error("command allowed while clock stopped");
  chk_clk_rwe: assert property (SUSPEND_RESUME_OK [*3] |-> !SD_CLK_STOP)
    else $error("clock stopped with read wait on");
  chk_cont_stop: assert property (CONTINUE_REQ |-> !STOP_AT_GAP)
    else $error("continue while stop requested");
  chk_cont_halted: assert property ($rose(CONTINUE_REQ) |-> $past(HALTED_AT_GAP))
    else $error("continue raised with no transfer halted");
  chk_cont_rd: assert property (!XFER_IS_WRITE && $rose(DAT_LINE_ACTIVE) |-> ##[1:2] !CONTINUE_REQ)
    else $error("continue not cleared on read restart");
  chk_cont_wr: assert property (XFER_IS_WRITE && $rose(WRITE_XFER_ACTIVE) |-> ##[1:2] !CONTINUE_REQ)
    else $error("continue not cleared on write restart");
endmodule
bind sdpbg_top sdpbg_properties u_chk (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .HSEL(HSEL), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .CARD_DETECT(CARD_DETECT),
  .DAT_LINE_ACTIVE(DAT_LINE_ACTIVE), .WRITE_XFER_ACTIVE(WRITE_XFER_ACTIVE), .XFER_IS_WRITE(XFER_IS_WRITE),
  .HALTED_AT_GAP(HALTED_AT_GAP),
  .SD_CLK_STOP(SD_CLK_STOP), .CMD_ALLOWED(CMD_ALLOWED), .SUSPEND_RESUME_OK(SUSPEND_RESUME_OK),
  .BUS_POWER_EN(BUS_POWER_EN), .BUS_VOLT_SEL(BUS_VOLT_SEL), .STOP_AT_GAP(STOP_AT_GAP),
  .CONTINUE_REQ(CONTINUE_REQ));
`default_nettype wire

/* File: sdpbg_card.sv */
// behavioural sd card: link clock and interrupt line
`timescale 1ns/1ps
`default_nettype none
module sdpbg_card
(
  input wire logic run,
  input wire logic int_req,
  output logic sd_clk,
  output logic dat1,
  output logic rw_ok
);
  // card reports read wait support, so the host may enable it
  localparam logic READ_WAIT_OK = 1'b1;
  // ****
  // link clock, still outside frames
  // ****
  initial
  begin
    sd_clk = 1'b0;
    // odd offset keeps edges off the system clock edges
    #137;
    forever
    begin
      #400;
      sd_clk = run ? ~sd_clk : 1'b0;
    end
  end
  // line has a pull-up: released reads high, interrupt is a low level
  assign dat1 = int_req ? 1'b0 : 1'b1;
  // capability seen by the driver when it programs read wait
  assign rw_ok = READ_WAIT_OK;
endmodule
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the sd power and block-gap block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {logic [9:0] a; logic [7:0] w; logic [7:0] e;} sdpbg_row_t;
  logic clk, rst_b, hsel, hwrite, cd, w4, dla, wxa, xw, mb, gap, halt, hold, run, ireq, sdclk, dat1;
  logic hready, irq, d2o, d2oe, cstop, cmdok, srok, pwr, stop, cont, hresp, rwok;
  logic [1:0] htrans;
  logic [2:0] volt;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int errors, checked, i;
  // first row sets the voltage alone; power is enabled only afterwards, once card detect has settled
  sdpbg_row_t rows [10] = '{'{10'h0A4, 8'h0E, 8'h0E}, '{10'h0A4, 8'h0F, 8'h0F}, '{10'h0A4, 8'h0B, 8'h0B},
    '{10'h0A4, 8'h09, 8'h0B}, '{10'h0A4, 8'hF3, 8'hFB}, '{10'h0A4, 8'h0D, 8'h0D}, '{10'h0A8, 8'hFC, 8'h0C},
    '{10'h0A8, 8'h02, 8'h00}, '{10'h100, 8'hFF, 8'h00}, '{10'h0C4, 8'h07, 8'h07}};
  sdpbg_top uut (.CLK_SYS(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .IRQ(irq),
    .CARD_DETECT(cd), .DATA_WIDTH_4BIT(w4), .DAT_LINE_ACTIVE(dla), .WRITE_XFER_ACTIVE(wxa), .XFER_IS_WRITE(xw),
    .MULTI_BLOCK(mb), .IN_BLOCK_GAP(gap), .HALTED_AT_GAP(halt), .HOLD_READ_DATA(hold), .SD_CLK(sdclk),
    .CARD_DAT1_IN(dat1), .CARD_DAT2_OUT(d2o), .CARD_DAT2_OE(d2oe), .SD_CLK_STOP(cstop), .CMD_ALLOWED(cmdok),
    .SUSPEND_RESUME_OK(srok), .BUS_POWER_EN(pwr), .BUS_VOLT_SEL(volt), .STOP_AT_GAP(stop), .CONTINUE_REQ(cont));
  sdpbg_card card (.run(run), .int_req(ireq), .sd_clk(sdclk), .dat1(dat1), .rw_ok(rwok));
  // ****
  // bus master, compare and verdict
  // ****
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= sdpbg_pkg::HTRANS_NONSEQ;
    haddr <= {22'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    test_done;
  end
  initial
  begin
    {rst_b, hsel, hwrite, w4, dla, wxa, xw, mb, gap, halt, hold, run, ireq} = '0;
    cd = 1'b1;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].a, {24'h0, rows[i].w});
      bus(1'b0, rows[i].a, 32'h0);
      chk(rd, {24'h0, rows[i].e});
    end
    chk({27'h0, hresp, pwr, volt}, 32'h0E);
    // read wait on, then off, while the data path holds reads
    run <= 1'b1;
    hold <= 1'b1;
    for (i = 0; i < 2; i++)
    begin
      bus(1'b1, 10'h0A8, i ? 32'h08 : {28'h0, 1'b1, rwok, 2'h0});
      repeat (30) @(posedge clk);
      chk({27'h0, d2o, d2oe, cstop, cmdok, srok}, i ? 32'h04 : 32'h0B);
    end
    hold <= 1'b0;
    {mb, gap, ireq} <= 3'h7;
    for (i = 0; i < 2; i++)
    begin
      w4 <= i[0];
      repeat (40) @(posedge clk);
      bus(1'b0, 10'h0C0, 32'h0);
      chk(rd, i);
    end
    {mb, gap, ireq, run} <= 4'h0;
    repeat (20) @(posedge clk);
    bus(1'b0, 10'h0C0, 32'h0);
    cd <= 1'b0;
    repeat (6) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, 10'h0C0, 32'h0);
    chk(rd, 32'h2);
    bus(1'b1, 10'h0A4, 32'h0D);
    bus(1'b0, 10'h0A4, 32'h0);
    chk({irq, rd[30:0]}, 32'h0C);
    chk({27'h0, hresp, pwr, volt}, 32'h06);
    cd <= 1'b1;
    halt <= 1'b1;
    for (i = 0; i < 2; i++)
    begin
      xw <= i[0];
      // stop is requested with no write data pending
      bus(1'b1, 10'h0A8, 32'h01);
      @(posedge clk);
      chk({30'h0, stop, cont}, 32'h2);
      bus(1'b1, 10'h0A8, 32'h02);
      @(posedge clk);
      chk({30'h0, stop, cont}, 32'h1);
      {wxa, dla} <= i ? 2'b10 : 2'b01;
      repeat (3) @(posedge clk);
      bus(1'b0, 10'h0C0, 32'h0);
      chk({cont, rd[30:0]}, 32'h4);
      {wxa, dla} <= 2'h0;
    end
    halt <= 1'b0;
    bus(1'b1, 10'h0A4, 32'hFD);
    rst_b <= 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    bus(1'b0, 10'h0A4, 32'h0);
    chk(rd, 32'h0C);
    bus(1'b0, 10'h0A8, 32'h0);
    chk(rd, 32'h0);
    test_done;
  end
endmodule
`default_nettype wire
